// *** verilog/rpc_pkg.sv ***
// ==========================================================
// Receive payload conditioning constants and types
package rpc_pkg;
  // ========================================================
  // Direct register offsets
  localparam logic [7:0] RPC_AUTO_OFS   = 8'h00;
  localparam logic [7:0] RPC_FORCE_OFS  = 8'h01;
  localparam logic [7:0] RPC_ROUTE_OFS  = 8'h0F;
  localparam logic [7:0] RPC_ENABLE_OFS = 8'h50;
  localparam logic [7:0] RPC_STATUS_OFS = 8'h51;
  localparam logic [7:0] RPC_IADDR_OFS  = 8'h52;
  localparam logic [7:0] RPC_IDATA_OFS  = 8'h53;
  localparam logic [7:0] RPC_RESET_VAL  = 8'h00;
  // ========================================================
  // Field positions of direct registers
  localparam int RPC_AUTO_OOF_BIT  = 1;
  localparam int RPC_AUTO_RED_BIT  = 2;
  localparam int RPC_FORCE_BIT     = 0;
  localparam int RPC_UNFRAMED_EXTRACT_SELECT_BIT   = 0;
  localparam int RPC_UNFRAMED_REPLACE_SELECT_BIT   = 1;
  localparam int RPC_DIR_BIT       = 2;
  localparam int RPC_FRAC_DET_BIT  = 3;
  localparam int RPC_FRAC_GEN_BIT  = 4;
  localparam int RPC_SEL_LSB       = 5;
  localparam int RPC_PER_CHANNEL_CONFIG_ENABLE_BIT      = 0;
  localparam int RPC_BUSY_BIT      = 7;
  localparam int RPC_RDIR_BIT      = 7;
  // ========================================================
  // Indirect space: config 01-18H, trunk 19-30H, signaling 31-48H
  localparam logic [6:0] RPC_IND_FIRST = 7'h01;
  localparam logic [6:0] RPC_IND_LAST  = 7'h48;
  localparam int RPC_CHANNELS   = 24;
  localparam int RPC_TRUNK_BASE = 24;
  localparam int RPC_SIG_BASE   = 48;
  localparam int RPC_IND_WORDS  = 72;
  // Per-channel config and signaling fields
  localparam int RPC_INV_BIT    = 7;
  localparam int RPC_TRK_BIT    = 6;
  localparam int RPC_MW_BIT     = 5;
  localparam int RPC_MSB_BIT    = 4;
  localparam int RPC_TEST_BIT   = 3;
  localparam int RPC_FIX_BIT    = 1;
  localparam int RPC_POL_BIT    = 0;
  localparam int RPC_STRK_BIT   = 7;
  // ========================================================
  // Indirect access timing
  localparam int RPC_CLK_NS     = 8;
  localparam int RPC_BUSY_NS    = 650;
  localparam int RPC_BUSY_CYC   = (RPC_BUSY_NS + RPC_CLK_NS - 1) / RPC_CLK_NS;
  // ========================================================
  // One channel word of the receive stream
  typedef struct packed {
    logic [4:0] chan;
    logic       fbit;
    logic [7:0] data;
    logic [3:0] sig;
  } rpc_word_t;
endpackage

// *** verilog/rpc_payload_ctrl.sv ***
// How it works
// - Per-channel indirect settings act only while the enable bit is set, except trunk codes used by auto trunking.
// - Direction 0: selected framer's data is copied to the detector.
// - Unframed extract takes all channels and F-bit, else test channels.
// - Fractional extract takes only the seven data bits of a channel.
// - Trunk code enable swaps the channel byte for its trunk code.
// - Lost multiframe sync with auto bit trunks every channel.
// - Red alarm with auto bit trunks every channel.
// - Milliwatt enable emits the eight-byte mu-law milliwatt cycle.
// - Direction 1: generator pattern replaces data, unframed or flagged.
// - Sign flip inverts the msb, invert flips the other seven bits.
// - Fix bit forces the channel signaling to its polarity bit.
// - Treatments resolve: extract, trunk, milliwatt, pattern, invert.
// - Signaling trunk enable replaces signaling with stored ABCD.
// - Force bit with enable trunks all data and signaling.
// - Busy stays high for the whole 650 ns indirect access.
`timescale 1ns/1ps
`default_nettype none
module rpc_payload_ctrl
  import rpc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Framer identity and alarm pins
  input  wire logic [2:0] framer_index,
  input  wire logic       sync_lost_pin,
  input  wire logic       red_alarm_pin,
  // Received channel words
  input  wire rpc_word_t  in_word,
  input  wire logic       in_valid,
  output logic            in_ready,
  // Shared pattern unit
  input  wire logic [7:0] gen_data,
  output logic            ext_valid,
  output logic      [7:0] ext_data,
  output logic            ext_fbit,
  // System side output
  output rpc_word_t       out_word,
  output logic            out_valid,
  input  wire logic       out_ready
);
  // ========================================================
  // Milliwatt byte, bit 0 is the lsb
  function automatic logic [7:0] mw_byte(input logic [2:0] ph);
    case (ph)
      3'h0, 3'h3: mw_byte = 8'h78;
      3'h1, 3'h2: mw_byte = 8'hD0;
      3'h4, 3'h7: mw_byte = 8'h79;
      default:    mw_byte = 8'hD1;
    endcase
  endfunction

  // ========================================================
  // Registers
  logic [7:0] auto_conditioning_control;
  logic [7:0] receive_trunk_force_control;
  logic [7:0] pattern_unit_routing;
  logic [7:0] payload_config_enable;
  logic [7:0] indirect_address_select;
  logic [7:0] indirect_data_port;
  logic [7:0] ind_mem [RPC_IND_WORDS];
  logic [6:0] busy_cnt;
  logic       busy;
  logic [1:0] oof_sync;
  logic [1:0] red_sync;
  logic [2:0] mw_phase;
  logic       in_fire;
  logic [6:0] ind_idx;
  logic       ind_hit;
  logic       start_access;
  logic [4:0] ch;
  logic [7:0] cfg;
  logic [7:0] trunk;
  logic [7:0] sigt;
  logic       per_channel_config_enable;
  logic       framer_hit;
  logic       do_ext;
  logic       do_gen;
  logic       all_trunk;
  logic       force_all;
  rpc_word_t  next_word;
  rpc_word_t  fifo [2];
  logic       wr_ptr;
  logic       rd_ptr;
  logic [1:0] count;

  assign start_access = reg_wr && reg_addr == RPC_IADDR_OFS && !busy;
  assign ind_idx      = indirect_address_select[6:0] - RPC_IND_FIRST;
  assign ind_hit      = indirect_address_select[6:0] >= RPC_IND_FIRST &&
                        indirect_address_select[6:0] <= RPC_IND_LAST;
  assign busy         = busy_cnt != 7'h0;

  // Direct register writes
  always_ff @(posedge clk) begin
    if (reset) begin
      auto_conditioning_control   <= RPC_RESET_VAL;
      receive_trunk_force_control <= RPC_RESET_VAL;
      pattern_unit_routing        <= RPC_RESET_VAL;
      payload_config_enable       <= RPC_RESET_VAL;
      indirect_address_select     <= RPC_RESET_VAL;
    end else if (reg_wr) begin
      case (reg_addr)
        RPC_AUTO_OFS:   auto_conditioning_control   <= reg_wdata;
        RPC_FORCE_OFS:  receive_trunk_force_control <= reg_wdata;
        RPC_ROUTE_OFS:  pattern_unit_routing        <= reg_wdata;
        RPC_ENABLE_OFS: payload_config_enable       <= reg_wdata;
        RPC_IADDR_OFS: begin
          if (!busy)
            indirect_address_select <= reg_wdata;
        end
        default: ;
      endcase
    end
  end

  // Access timer, the transfer happens on the last busy cycle
  always_ff @(posedge clk) begin
    if (reset)
      busy_cnt <= 7'h0;
    else if (start_access)
      busy_cnt <= 7'(RPC_BUSY_CYC);
    else if (busy)
      busy_cnt <= busy_cnt - 7'h1;
  end

  // Data register: software write or indirect read result
  always_ff @(posedge clk) begin
    if (reset)
      indirect_data_port <= RPC_RESET_VAL;
    else if (busy_cnt == 7'h1 && indirect_address_select[RPC_RDIR_BIT])
      indirect_data_port <= ind_hit ? ind_mem[ind_idx] : RPC_RESET_VAL;
    else if (reg_wr && reg_addr == RPC_IDATA_OFS)
      indirect_data_port <= reg_wdata;
  end

  // Indirect store, written when a write access completes
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int i = 0; i < RPC_IND_WORDS; i++)
        ind_mem[i] <= RPC_RESET_VAL;
    end else if (busy_cnt == 7'h1 && ind_hit &&
                 !indirect_address_select[RPC_RDIR_BIT]) begin
      ind_mem[ind_idx] <= indirect_data_port;
    end
  end

  // Register read data
  always_ff @(posedge clk) begin
    if (reset)
      reg_rdata <= RPC_RESET_VAL;
    else if (reg_rd) begin
      case (reg_addr)
        RPC_AUTO_OFS:   reg_rdata <= auto_conditioning_control;
        RPC_FORCE_OFS:  reg_rdata <= receive_trunk_force_control;
        RPC_ROUTE_OFS:  reg_rdata <= pattern_unit_routing;
        RPC_ENABLE_OFS: reg_rdata <= payload_config_enable;
        RPC_STATUS_OFS: reg_rdata <= {busy, 7'h0};
        RPC_IADDR_OFS:  reg_rdata <= indirect_address_select;
        RPC_IDATA_OFS:  reg_rdata <= indirect_data_port;
        default:        reg_rdata <= RPC_RESET_VAL;
      endcase
    end
  end

  // Alarm pin synchronisers
  always_ff @(posedge clk) begin
    if (reset) begin
      oof_sync <= 2'h0;
      red_sync <= 2'h0;
    end else begin
      oof_sync <= {oof_sync[0], sync_lost_pin};
      red_sync <= {red_sync[0], red_alarm_pin};
    end
  end

  // ========================================================
  // Channel treatment
  assign in_fire    = in_valid && in_ready;
  assign ch         = in_word.chan < 5'(RPC_CHANNELS) ? in_word.chan : 5'h0;
  assign cfg        = ind_mem[ch];
  assign trunk      = ind_mem[RPC_TRUNK_BASE + ch];
  assign sigt       = ind_mem[RPC_SIG_BASE + ch];
  assign per_channel_config_enable       = payload_config_enable[RPC_PER_CHANNEL_CONFIG_ENABLE_BIT];
  assign framer_hit = pattern_unit_routing[7:RPC_SEL_LSB] == framer_index;
  assign force_all  = per_channel_config_enable && receive_trunk_force_control[RPC_FORCE_BIT];
  assign all_trunk  = force_all ||
    (oof_sync[1] && auto_conditioning_control[RPC_AUTO_OOF_BIT]) ||
    (red_sync[1] && auto_conditioning_control[RPC_AUTO_RED_BIT]);
  assign do_ext = framer_hit && !pattern_unit_routing[RPC_DIR_BIT] &&
    (pattern_unit_routing[RPC_UNFRAMED_EXTRACT_SELECT_BIT] ||
     (!in_word.fbit && per_channel_config_enable && cfg[RPC_TEST_BIT]));
  assign do_gen = framer_hit && pattern_unit_routing[RPC_DIR_BIT] &&
    (pattern_unit_routing[RPC_UNFRAMED_REPLACE_SELECT_BIT] ||
     (!in_word.fbit && per_channel_config_enable && cfg[RPC_TEST_BIT]));

  // Priority resolution of data and signaling
  always_comb begin
    next_word = in_word;
    if (do_ext) begin
      next_word.data = in_word.data;
    end else if (in_word.fbit) begin
      next_word.data = in_word.data;
    end else if (all_trunk || (per_channel_config_enable && cfg[RPC_TRK_BIT])) begin
      next_word.data = trunk;
    end else if (per_channel_config_enable && cfg[RPC_MW_BIT]) begin
      next_word.data = mw_byte(mw_phase);
    end else if (do_gen) begin
      next_word.data = gen_data;
      if (pattern_unit_routing[RPC_FRAC_GEN_BIT])
        next_word.data[0] = in_word.data[0];
    end else if (per_channel_config_enable) begin
      next_word.data[7]   = in_word.data[7] ^ cfg[RPC_MSB_BIT];
      next_word.data[6:0] = in_word.data[6:0] ^ {7{cfg[RPC_INV_BIT]}};
    end
    if (do_gen && in_word.fbit)
      next_word.data = gen_data;
    if (force_all || (per_channel_config_enable && sigt[RPC_STRK_BIT]))
      next_word.sig = sigt[3:0];
    else if (per_channel_config_enable && cfg[RPC_FIX_BIT])
      next_word.sig = {4{cfg[RPC_POL_BIT]}};
  end

  // Detector tap and milliwatt phase
  always_ff @(posedge clk) begin
    if (reset) begin
      ext_valid <= 1'b0;
      ext_data  <= 8'h00;
      ext_fbit  <= 1'b0;
      mw_phase  <= 3'h0;
    end else begin
      ext_valid <= in_fire && do_ext;
      if (in_fire && do_ext) begin
        ext_data <= in_word.data;
        ext_fbit <= in_word.fbit;
        if (pattern_unit_routing[RPC_FRAC_DET_BIT] && !in_word.fbit)
          ext_data[0] <= 1'b0;
      end
      if (in_fire && in_word.fbit)
        mw_phase <= mw_phase + 3'h1;
    end
  end

  // ========================================================
  // Two-entry output buffer
  assign in_ready  = count != 2'h2;
  assign out_valid = count != 2'h0;
  assign out_word  = fifo[rd_ptr];

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr  <= 1'b0;
      rd_ptr  <= 1'b0;
      count   <= 2'h0;
      fifo[0] <= '0;
      fifo[1] <= '0;
    end else begin
      if (in_fire) begin
        fifo[wr_ptr] <= next_word;
        wr_ptr       <= !wr_ptr;
      end
      if (out_valid && out_ready)
        rd_ptr <= !rd_ptr;
      count <= count + 2'(in_fire) - 2'(out_valid && out_ready);
    end
  end

  // ========================================================
  // Checks
  property p_busy_len;
    @(posedge clk) disable iff (reset)
      start_access |=> busy [*8] ##74 busy ##1 !busy;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("busy length wrong");

  property p_no_per_channel_config_enable;
    @(posedge clk) disable iff (reset)
      in_fire && !per_channel_config_enable && !all_trunk && !do_ext && !do_gen
        |-> next_word == in_word;
  endproperty
  a_no_per_channel_config_enable: assert property (p_no_per_channel_config_enable)
    else $error("settings applied without enable");

  property p_ext;
    @(posedge clk) disable iff (reset)
      in_fire && framer_hit && !pattern_unit_routing[RPC_DIR_BIT] &&
      pattern_unit_routing[RPC_UNFRAMED_EXTRACT_SELECT_BIT] |=> ext_valid;
  endproperty
  a_ext: assert property (p_ext)
    else $error("unframed word not extracted");

  property p_oof;
    @(posedge clk) disable iff (reset)
      in_fire && !in_word.fbit && !do_ext && oof_sync[1] &&
      auto_conditioning_control[RPC_AUTO_OOF_BIT] |-> next_word.data == trunk;
  endproperty
  a_oof: assert property (p_oof)
    else $error("sync loss did not trunk");

  property p_red;
    @(posedge clk) disable iff (reset)
      in_fire && !in_word.fbit && !do_ext && red_sync[1] &&
      auto_conditioning_control[RPC_AUTO_RED_BIT] |-> next_word.data == trunk;
  endproperty
  a_red: assert property (p_red)
    else $error("red alarm did not trunk");

  property p_force_sig;
    @(posedge clk) disable iff (reset)
      in_fire && force_all |-> next_word.sig == sigt[3:0];
  endproperty
  a_force_sig: assert property (p_force_sig)
    else $error("forced signaling wrong");

  property p_mw;
    @(posedge clk) disable iff (reset)
      in_fire && !in_word.fbit && !do_ext && !all_trunk && per_channel_config_enable &&
      !cfg[RPC_TRK_BIT] && cfg[RPC_MW_BIT] |-> next_word.data[0] == mw_phase[2];
  endproperty
  a_mw: assert property (p_mw)
    else $error("milliwatt byte wrong");

  property p_out_hold;
    @(posedge clk) disable iff (reset)
      out_valid && !out_ready |=> out_valid && $stable(out_word);
  endproperty
  a_out_hold: assert property (p_out_hold)
    else $error("stalled output changed");
endmodule
`default_nettype wire

// *** tb/rpc_sys_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// System receiver and shared pattern generator
module rpc_sys_model
  import rpc_pkg::*;
(
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      reset,
  // Test control
  input  wire logic      stall,
  // Conditioned stream from the block
  input  wire rpc_word_t out_word,
  input  wire logic      out_valid,
  output logic           out_ready,
  // Generator byte toward the block
  output logic     [7:0] gen_data,
  // Words taken so far
  output rpc_word_t      got_word,
  output logic    [15:0] got_cnt
);
  // Receiver holds off while stalled
  assign out_ready = ~stall;
  // Generator steps every cycle so a stale byte shows
  always_ff @(posedge clk) begin
    if (reset) begin
      gen_data <= 8'h00;
    end else begin
      gen_data <= gen_data + 8'h35;
    end
  end
  // Capture each word handed over
  always_ff @(posedge clk) begin
    if (reset) begin
      got_cnt  <= 16'h0000;
      got_word <= '0;
    end else if (out_valid && out_ready) begin
      got_cnt  <= got_cnt + 16'h0001;
      got_word <= out_word;
    end
  end
endmodule
`default_nettype wire

// *** tb/receive_payload_control_t1_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Bench for receive payload conditioning
module receive_payload_control_t1_tb import rpc_pkg::*;;
  logic        clk, reset, reg_wr, reg_rd, in_valid, in_ready, stall;
  logic        sync_lost_pin, red_alarm_pin, ext_valid, ext_fbit;
  logic        out_valid, out_ready;
  logic  [7:0] reg_addr, reg_wdata, reg_rdata, gen_data, ext_data;
  logic  [7:0] ext_last, gen_seen, q;
  logic  [2:0] framer_index;
  logic [15:0] got_cnt;
  rpc_word_t   in_word, out_word, got_word, w;
  int          miscompares, n_tests, ext_cnt;
  // Design and far side
  rpc_payload_ctrl rpc_payload_ctrl_inst (.clk(clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .framer_index(framer_index), .sync_lost_pin(sync_lost_pin),
    .red_alarm_pin(red_alarm_pin), .in_word(in_word),
    .in_valid(in_valid), .in_ready(in_ready), .gen_data(gen_data),
    .ext_valid(ext_valid), .ext_data(ext_data), .ext_fbit(ext_fbit),
    .out_word(out_word), .out_valid(out_valid), .out_ready(out_ready));
  rpc_sys_model rpc_sys_model_inst (.clk(clk), .reset(reset),
    .stall(stall), .out_word(out_word), .out_valid(out_valid),
    .out_ready(out_ready), .gen_data(gen_data), .got_word(got_word),
    .got_cnt(got_cnt));
  // Clock
  initial clk = 1'b0;
  always #4 clk = ~clk;
  // Extract monitor
  always @(posedge clk) begin
    if (reset) begin
      ext_cnt  <= 0;
      ext_last <= 8'h00;
    end else if (ext_valid === 1'b1) begin
      ext_cnt  <= ext_cnt + 1;
      ext_last <= ext_data;
    end
  end
  // ========================================================
  // Shared tasks
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask
  // Indirect access: data first, then address, then poll busy
  task automatic ind(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    wr(RPC_IDATA_OFS, d);
    wr(RPC_IADDR_OFS, a);
    rdr(RPC_STATUS_OFS, q);
    chk(q, 8'h80);
    while (q[RPC_BUSY_BIT] !== 1'b0 && n < 100) begin
      rdr(RPC_STATUS_OFS, q);
      n++;
    end
    // Polls sample every third edge, two edges after the launch
    chk({7'h00, n == (RPC_BUSY_CYC + 1) / 3}, 8'h01);
    rdr(RPC_IDATA_OFS, q);
  endtask
  task automatic send(input logic [4:0] ch, input logic f,
                      input logic [7:0] d);
    int n;
    logic [15:0] c0;
    n = 0;
    c0 = got_cnt;
    @(posedge clk);
    in_valid <= 1'b1;
    in_word  <= '{chan: ch, fbit: f, data: d, sig: 4'h5};
    do @(posedge clk); while (in_ready !== 1'b1);
    gen_seen = gen_data;
    in_valid <= 1'b0;
    while (got_cnt == c0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    w = got_word;
  endtask
  task automatic sc(input logic [4:0] ch, input logic [7:0] d,
                    input logic [7:0] ed, input logic [3:0] es);
    send(ch, 1'b0, d);
    chk(w.data, ed);
    chk({4'h0, w.sig}, {4'h0, es});
  endtask
  // ========================================================
  // Scenarios
  task automatic t_regs();
    logic [7:0] ofs [8] = '{8'h00, 8'h01, 8'h0F, 8'h50, 8'h51, 8'h52,
                            8'h53, 8'h10};
    foreach (ofs[i]) begin
      rdr(ofs[i], q);
      chk(q, RPC_RESET_VAL);
    end
    wr(RPC_STATUS_OFS, 8'hFF);
    rdr(RPC_STATUS_OFS, q);
    chk(q, 8'h00);
    wr(RPC_ROUTE_OFS, 8'hA5);
    rdr(RPC_ROUTE_OFS, q);
    chk(q, 8'hA5);
    wr(RPC_ROUTE_OFS, 8'h00);
    ind(8'h48, 8'h6A);
    ind(8'hC8, 8'h00);
    chk(q, 8'h6A);
    ind(8'h49, 8'h77);
    ind(8'hC9, 8'h00);
    chk(q, 8'h00);
    $display("t_regs done");
  endtask
  task automatic t_chan();
    logic [15:0] cf [8] = '{16'h0440, 16'h1C5A, 16'h348C, 16'h0503,
                            16'h0690, 16'h0710, 16'h08C0, 16'h2066};
    foreach (cf[i]) ind(cf[i][15:8], cf[i][7:0]);
    sc(5'h03, 8'h11, 8'h11, 4'h5);
    wr(RPC_ENABLE_OFS, 8'h01);
    sc(5'h03, 8'h11, 8'h5A, 4'hC);
    sc(5'h04, 8'h22, 8'h22, 4'hF);
    sc(5'h05, 8'h0F, 8'hF0, 4'h5);
    sc(5'h06, 8'h0F, 8'h8F, 4'h5);
    sc(5'h07, 8'h0F, 8'h66, 4'h5);
    $display("t_chan done");
  endtask
  task automatic t_mw();
    logic [7:0] mw [8] = '{8'h78, 8'hD0, 8'hD0, 8'h78, 8'h79, 8'hD1,
                           8'hD1, 8'h79};
    logic [7:0] got [9];
    logic ok, m;
    ok = 1'b0;
    ind(8'h0A, 8'h20);
    for (int i = 0; i < 9; i++) begin
      send(5'h00, 1'b1, 8'h00);
      send(5'h09, 1'b0, 8'h00);
      got[i] = w.data;
    end
    for (int k = 0; k < 8; k++) begin
      m = 1'b1;
      for (int i = 0; i < 9; i++) if (got[i] !== mw[(k + i) % 8]) m = 1'b0;
      if (m) ok = 1'b1;
    end
    chk({7'h00, ok}, 8'h01);
    $display("t_mw done");
  endtask
  task automatic t_auto();
    wr(RPC_ENABLE_OFS, 8'h00);
    ind(8'h25, 8'h3E);
    ind(8'h3D, 8'h87);
    wr(RPC_AUTO_OFS, 8'h02);
    sync_lost_pin <= 1'b1;
    repeat (4) @(posedge clk);
    sc(5'h0C, 8'h99, 8'h3E, 4'h5);
    sync_lost_pin <= 1'b0;
    wr(RPC_AUTO_OFS, 8'h04);
    red_alarm_pin <= 1'b1;
    repeat (4) @(posedge clk);
    sc(5'h0C, 8'h99, 8'h3E, 4'h5);
    red_alarm_pin <= 1'b0;
    wr(RPC_AUTO_OFS, 8'h00);
    wr(RPC_FORCE_OFS, 8'h01);
    repeat (4) @(posedge clk);
    sc(5'h0C, 8'h99, 8'h99, 4'h5);
    wr(RPC_ENABLE_OFS, 8'h01);
    sc(5'h0C, 8'h99, 8'h3E, 4'h7);
    wr(RPC_FORCE_OFS, 8'h00);
    $display("t_auto done");
  endtask
  task automatic t_pat();
    int e0;
    ind(8'h0B, 8'h48);
    ind(8'h23, 8'h77);
    ind(8'h0E, 8'h08);
    wr(RPC_ROUTE_OFS, 8'h41);
    e0 = ext_cnt;
    sc(5'h0B, 8'h3C, 8'h3C, 4'h5);
    send(5'h00, 1'b1, 8'h00);
    chk(8'(ext_cnt - e0), 8'h02);
    chk({7'h00, ext_fbit}, 8'h01);
    wr(RPC_ROUTE_OFS, 8'h40);
    sc(5'h0B, 8'h3C, 8'h3C, 4'h5);
    chk(8'(ext_cnt - e0), 8'h02);
    sc(5'h0A, 8'h3D, 8'h3D, 4'h5);
    chk(ext_last, 8'h3D);
    wr(RPC_ROUTE_OFS, 8'h48);
    send(5'h0A, 1'b0, 8'h3D);
    chk(ext_last, 8'h3C);
    wr(RPC_ROUTE_OFS, 8'h60);
    sc(5'h0A, 8'h3D, 8'h77, 4'h5);
    chk(8'(ext_cnt - e0), 8'h04);
    wr(RPC_ROUTE_OFS, 8'h46);
    send(5'h0B, 1'b0, 8'h3C);
    chk(w.data, gen_seen);
    wr(RPC_ROUTE_OFS, 8'h44);
    sc(5'h0B, 8'h3C, 8'h3C, 4'h5);
    send(5'h0D, 1'b0, 8'h3C);
    chk(w.data, gen_seen);
    wr(RPC_ROUTE_OFS, 8'h54);
    send(5'h0D, 1'b0, 8'h3D);
    chk(w.data, {gen_seen[7:1], 1'b1});
    wr(RPC_ROUTE_OFS, 8'h00);
    $display("t_pat done");
  endtask
  // Receiver stalls: two words held, none lost
  task automatic t_buf();
    int n;
    logic [15:0] c0;
    n = 0;
    c0 = got_cnt;
    @(posedge clk);
    stall    <= 1'b1;
    in_valid <= 1'b1;
    in_word  <= '{chan: 5'h14, fbit: 1'b0, data: 8'h00, sig: 4'h5};
    repeat (6) begin
      @(posedge clk);
      if (in_ready === 1'b1) begin
        n++;
        in_word.data <= n[7:0];
      end
    end
    chk(n[7:0], 8'h02);
    stall <= 1'b0;
    // Third word stays offered until the buffer takes it
    do @(posedge clk); while (in_ready !== 1'b1);
    in_valid <= 1'b0;
    repeat (6) @(posedge clk);
    chk(got_cnt[7:0] - c0[7:0], 8'h03);
    chk(got_word.data, 8'h02);
    $display("t_buf done");
  endtask
  // Main sequence
  initial begin
    {reset, stall} = 2'b10;
    {reg_wr, reg_rd, in_valid, sync_lost_pin, red_alarm_pin} = 5'h00;
    {reg_addr, reg_wdata} = 16'h0000;
    in_word = '0;
    framer_index = 3'h2;
    miscompares = 0;
    n_tests = 0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_chan();
    t_mw();
    t_auto();
    t_pat();
    t_buf();
    complete_run();
  end
  // Watchdog
  initial begin
    #400000;
    miscompares++;
    complete_run();
  end
endmodule
`default_nettype wire
